//--- design/csc_ctrl.sv
// CPU operating state controller with bus clock, strobes and pin enable control.
// Notes on behaviour
// - System clock is the oscillator input rate divided by four.
// - Bus clock output runs at one quarter of oscillator rate.
// - Falling edge of unmaskable interrupt starts its sequence after current instruction.
// - Unmaskable interrupt is taken regardless of the interrupt mask bit.
// - Both level interrupt inputs request service while low, not on edges.
// - Mode pins select expanded mode 1, expanded mode 2 or single-chip mode 3.
// - Stop request low: finish instruction, release buses, enter halt.
// - Bus released flag low normally, high once halt accepted and buses released.
// - Memory wait request stretches the bus clock high phase until access completes.
// - Read strobe low on reads, store strobe low on writes.
// - Direction output high while reading, low while writing.
// - Opcode fetch strobe low only during opcode fetch cycles.
// - Expanded modes use port pins as address and data bus; mode 3 as ports.
// - Mode 3 turns the strobe pins into a five-bit output-only port.
// - Programming accesses honoured only while program select is low.
// - Fetch-execute starts after reset and repeats until a state change.
// - Standby floats every port pin and the bus clock output.
// - Expanded reset or sleep: strobes high, bus released low.
// - Expanded halt: float read, write, direction; opcode fetch and released high.
// - Halt requests are ignored in single-chip mode 3.
// - Keep state retains driven outputs and floats input pins.
// - Mode 2 sleep: upper address outputs high, upper inputs floated.
// - Halt ends on stop request high, or on reset or standby.
// - Reset release latches mode, sets mask, loads start address vector.
`default_nettype none
module csc_ctrl (
   input  wire logic        mclk_i,
   input  wire logic        nrst_i,
   input  wire logic        osc_in,
   input  wire logic        unmaskable_irq_n_i,
   input  wire logic        level_irq_a_n_i,
   input  wire logic        level_irq_b_n_i,
   input  wire logic        mode_pin_0_i,
   input  wire logic        mode_pin_1_i,
   input  wire logic        stop_request_n_i,
   input  wire logic        memory_wait_req_i,
   input  wire logic        deep_sleep_n_i,
   input  wire logic        prog_select_n_i,
   input  wire logic        sleep_opcode_i,
   input  wire logic        cycle_write_i,
   input  wire logic        insn_last_i,
   input  wire logic        irq_mask_clr_i,
   input  wire logic [4:0]  port7_out_i,
   input  wire logic [7:0]  port4_ddr_i,
   output logic             bus_clock_out_o,
   output logic             bus_clock_oe_n_o,
   output logic             read_strobe_n_o,
   output logic             store_strobe_n_o,
   output logic             direction_is_read_o,
   output logic             opcode_fetch_n_o,
   output logic             bus_released_o,
   output logic [4:0]       strobe_pins_oe_n_o,
   output logic             addr_lo_oe_n_o,
   output logic [7:0]       addr_hi_oe_n_o,
   output logic [7:0]       addr_hi_force_o,
   output logic             data_oe_n_o,
   output logic             bus_mode_o,
   output logic             port_keep_o,
   output logic [1:0]       mode_o,
   output logic             irq_mask_o,
   output logic [15:0]      vector_o,
   output logic             sys_tick_o,
   output logic             prog_enable_o,
   output logic [2:0]       state_o
);
   csc_sync_if sif ();
   csc_pkg::csc_state_type state;
   csc_pkg::csc_state_type next_state;
   logic [1:0]  div;
   logic        tick;
   logic        nmi_prev;
   logic        nmi_pend;
   logic        mode_valid;
   logic        expanded;
   logic [3:0]  cnt;
   logic        fetching;
   logic        halt_req;
   logic        irq_req;
   logic        running;

   // Asynchronous pins including the oscillator level pass two flip-flops.
   // input synchronisation
   csc_sync #(
      .WIDTH (10)
   ) u_sync (
      .mclk_i  (mclk_i),
      .nrst_i  (nrst_i),
      .async_i ({osc_in, mode_pin_1_i, mode_pin_0_i, prog_select_n_i, deep_sleep_n_i,
                 memory_wait_req_i, stop_request_n_i, level_irq_b_n_i, level_irq_a_n_i,
                 unmaskable_irq_n_i}),
      .sync    (sif)
   );

   // The divider steps on mclk_i, which stands for the oscillator input; osc_in itself
   // only passes the synchroniser and is left unused there, because a pin clock cannot be a second domain here.
   // divide by four
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         div <= 2'h0;
      end else if (tick || div != csc_pkg::DIV_LAST) begin
         div <= div + 2'h1;
      end
   end

   // Wait request freezes the divider in its last (high) phase while a bus access runs.
   // stretch high phase
   assign tick = (div == csc_pkg::DIV_LAST) &&
                 !(sif.wait_req && (state == csc_pkg::CSC_FETCH || state == csc_pkg::CSC_EXEC));

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         bus_clock_out_o <= 1'b0;
         sys_tick_o      <= 1'b0;
      end else begin
         bus_clock_out_o <= (next_div_high(div, tick));
         sys_tick_o      <= tick;
      end
   end

   function automatic logic next_div_high(input logic [1:0] d, input logic t);
      next_div_high = (d >= csc_pkg::DIV_RISE) && !t;
   endfunction

   // Mode tracks the straps during reset and freezes at release, so later pin wobble
   // cannot change the bus.
   // mode latch
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         mode_valid <= 1'b0;
         mode_o     <= sif.mode;
      end else if (!mode_valid) begin
         mode_valid <= 1'b1;
         mode_o     <= sif.mode;
      end
   end

   assign expanded = (mode_o == csc_pkg::MODE_EXP1) || (mode_o == csc_pkg::MODE_EXP2);

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         nmi_prev <= 1'b1;
         nmi_pend <= 1'b0;
      end else begin
         nmi_prev <= sif.nmi_n;
         if (nmi_prev && !sif.nmi_n) begin
            nmi_pend <= 1'b1;
         end else if (tick && next_state == csc_pkg::CSC_INTR &&
                      state != csc_pkg::CSC_INTR) begin
            // Cleared when the vector is chosen, so an edge during stacking is kept.
            nmi_pend <= 1'b0;
         end
      end
   end

   assign irq_req  = (!sif.irq_a_n || !sif.irq_b_n) && !irq_mask_o;
   assign halt_req = !sif.stop_n && expanded;
   assign running  = (state == csc_pkg::CSC_FETCH) || (state == csc_pkg::CSC_EXEC);

   always_comb begin
      next_state = state;
      case (state)
         csc_pkg::CSC_RESET: begin
            next_state = csc_pkg::CSC_BOOT;
         end
         csc_pkg::CSC_BOOT: begin
            if (cnt == 4'h0) begin
               next_state = csc_pkg::CSC_FETCH;
            end
         end
         csc_pkg::CSC_FETCH: begin
            next_state = csc_pkg::CSC_EXEC;
         end
         csc_pkg::CSC_EXEC: begin
            if (insn_last_i || cnt == 4'h0) begin
               if (nmi_pend || irq_req) begin
                  next_state = csc_pkg::CSC_INTR;
               end else if (halt_req) begin
                  next_state = csc_pkg::CSC_HALT;
               end else if (sleep_opcode_i) begin
                  next_state = csc_pkg::CSC_SLEEP;
               end else begin
                  next_state = csc_pkg::CSC_FETCH;
               end
            end
         end
         csc_pkg::CSC_INTR: begin
            if (cnt == 4'h0) begin
               next_state = csc_pkg::CSC_FETCH;
            end
         end
         csc_pkg::CSC_HALT: begin
            if (sif.stop_n) begin
               next_state = csc_pkg::CSC_FETCH;
            end
         end
         csc_pkg::CSC_SLEEP: begin
            if (nmi_pend || !sif.irq_a_n || !sif.irq_b_n) begin
               next_state = csc_pkg::CSC_INTR;
            end
         end
         csc_pkg::CSC_DEEP_SLEEP_N: begin
            next_state = csc_pkg::CSC_DEEP_SLEEP_N;
         end
         default: begin
            next_state = csc_pkg::CSC_RESET;
         end
      endcase
   end

   // Standby dominates every state and only reset leaves it.
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         state <= csc_pkg::CSC_RESET;
      end else if (!sif.sleep_n) begin
         state <= csc_pkg::CSC_DEEP_SLEEP_N;
      end else if (tick || state == csc_pkg::CSC_RESET) begin
         state <= next_state;
      end
   end

   // Cycle counter for boot, stacking and a fallback instruction length.
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         cnt <= 4'h0;
      end else if (state == csc_pkg::CSC_RESET) begin
         cnt <= csc_pkg::BOOT_CYCLES;
      end else if (tick) begin
         if (next_state == csc_pkg::CSC_INTR && state != csc_pkg::CSC_INTR) begin
            cnt <= csc_pkg::STACK_CYCLES;
         end else if (next_state == csc_pkg::CSC_EXEC && state != csc_pkg::CSC_EXEC) begin
            cnt <= csc_pkg::EXEC_CYCLES;
         end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         irq_mask_o <= 1'b1;
         vector_o   <= csc_pkg::VEC_RESET;
      end else if (tick && next_state == csc_pkg::CSC_INTR && state != csc_pkg::CSC_INTR) begin
         irq_mask_o <= 1'b1;
         vector_o   <= nmi_pend ? csc_pkg::VEC_NMI : csc_pkg::VEC_IRQ;
      end else if (irq_mask_clr_i) begin
         irq_mask_o <= 1'b0;
      end
   end

   assign fetching = (state == csc_pkg::CSC_FETCH);

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         read_strobe_n_o     <= 1'b1;
         store_strobe_n_o    <= 1'b1;
         direction_is_read_o <= 1'b1;
         opcode_fetch_n_o    <= 1'b1;
         bus_released_o      <= 1'b0;
      end else if (!expanded) begin
         {bus_released_o, opcode_fetch_n_o, direction_is_read_o, store_strobe_n_o,
          read_strobe_n_o} <= port7_out_i;
      end else if (state == csc_pkg::CSC_HALT) begin
         opcode_fetch_n_o <= 1'b1;
         bus_released_o   <= 1'b1;
      end else begin
         read_strobe_n_o     <= !(running && !cycle_write_i);
         store_strobe_n_o    <= !(running && cycle_write_i);
         direction_is_read_o <= !(running && cycle_write_i);
         opcode_fetch_n_o    <= !fetching;
         bus_released_o      <= 1'b0;
      end
   end

   // Pin enables are active low: zero means the block drives the pin.
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         bus_clock_oe_n_o   <= 1'b0;
         strobe_pins_oe_n_o <= {csc_pkg::STROBE_W{1'b1}};
         addr_lo_oe_n_o     <= 1'b1;
         addr_hi_oe_n_o     <= 8'hFF;
         addr_hi_force_o    <= 8'h00;
         data_oe_n_o        <= 1'b1;
         bus_mode_o         <= 1'b0;
         port_keep_o        <= 1'b0;
      end else if (state == csc_pkg::CSC_DEEP_SLEEP_N) begin
         bus_clock_oe_n_o   <= 1'b1;
         strobe_pins_oe_n_o <= {csc_pkg::STROBE_W{1'b1}};
         addr_lo_oe_n_o     <= 1'b1;
         addr_hi_oe_n_o     <= 8'hFF;
         addr_hi_force_o    <= 8'h00;
         data_oe_n_o        <= 1'b1;
         port_keep_o        <= 1'b0;
      end else begin
         bus_clock_oe_n_o   <= 1'b0;
         bus_mode_o         <= expanded;
         port_keep_o        <= (state == csc_pkg::CSC_SLEEP) ||
                               (expanded && state == csc_pkg::CSC_HALT);
         if (expanded) begin
            strobe_pins_oe_n_o <= (state == csc_pkg::CSC_HALT) ? 5'h07 : 5'h00;
            addr_lo_oe_n_o     <= (state == csc_pkg::CSC_HALT);
            data_oe_n_o        <= !(running && cycle_write_i);
            if (state == csc_pkg::CSC_SLEEP && mode_o == csc_pkg::MODE_EXP2) begin
               addr_hi_oe_n_o  <= ~port4_ddr_i;
               addr_hi_force_o <= port4_ddr_i;
            end else begin
               addr_hi_oe_n_o  <= (state == csc_pkg::CSC_HALT) ? 8'hFF : 8'h00;
               addr_hi_force_o <= (state == csc_pkg::CSC_SLEEP) ? 8'hFF : 8'h00;
            end
         end else begin
            strobe_pins_oe_n_o <= 5'h00;
            addr_lo_oe_n_o     <= 1'b1;
            addr_hi_oe_n_o     <= 8'hFF;
            addr_hi_force_o    <= 8'h00;
            data_oe_n_o        <= 1'b1;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         prog_enable_o <= 1'b0;
      end else begin
         prog_enable_o <= !sif.prog_n;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         state_o <= 3'h0;
      end else begin
         state_o <= state;
      end
   end
endmodule
`default_nettype wire

//--- design/csc_pkg.sv
// Package with constants and types for the CPU state and bus pin control block.
`default_nettype none
package csc_pkg;
   localparam int unsigned OSC_DIV      = 4;
   localparam logic [1:0]  DIV_LAST     = 2'h3;
   localparam logic [1:0]  DIV_RISE     = 2'h1;
   localparam logic [1:0]  MODE_EXP1    = 2'h1;
   localparam logic [1:0]  MODE_EXP2    = 2'h2;
   localparam logic [1:0]  MODE_SINGLE  = 2'h3;
   localparam int unsigned ADDR_W       = 16;
   localparam int unsigned DATA_W       = 8;
   localparam int unsigned STROBE_W     = 5;
   localparam logic [15:0] VEC_RESET    = 16'hFFFE;
   localparam logic [15:0] VEC_NMI      = 16'hFFFC;
   localparam logic [15:0] VEC_IRQ      = 16'hFFF8;
   localparam logic [3:0]  BOOT_CYCLES  = 4'h2;
   localparam logic [3:0]  STACK_CYCLES = 4'h7;
   localparam logic [3:0]  EXEC_CYCLES  = 4'h2;

   typedef enum logic [2:0] {
      CSC_RESET  = 3'h0,
      CSC_BOOT   = 3'h1,
      CSC_FETCH  = 3'h3,
      CSC_EXEC   = 3'h2,
      CSC_INTR   = 3'h6,
      CSC_HALT   = 3'h7,
      CSC_SLEEP  = 3'h5,
      CSC_DEEP_SLEEP_N   = 3'h4
   } csc_state_type;
endpackage
`default_nettype wire

//--- design/csc_sync_if.sv
// Interface carrying synchronised pin levels from the synchroniser to the controller.
`default_nettype none
interface csc_sync_if;
   logic nmi_n;
   logic irq_a_n;
   logic irq_b_n;
   logic stop_n;
   logic wait_req;
   logic sleep_n;
   logic prog_n;
   logic [1:0] mode;
   modport src (output nmi_n, irq_a_n, irq_b_n, stop_n, wait_req, sleep_n, prog_n, mode);
   modport dst (input nmi_n, irq_a_n, irq_b_n, stop_n, wait_req, sleep_n, prog_n, mode);
endinterface
`default_nettype wire

//--- design/csc_sync.sv
// Two-stage synchroniser bank for the asynchronous control pins.
`default_nettype none
module csc_sync #(
   parameter int unsigned WIDTH = 10
) (
   input  wire logic             mclk_i,
   input  wire logic             nrst_i,
   input  wire logic [WIDTH-1:0] async_i,
   csc_sync_if.src               sync
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;

   // The stages carry no reset so that the mode straps have settled through both
   // flip-flops when reset is released; every consumer gives its own reset priority.
   always_ff @(posedge mclk_i) begin
      stage1 <= async_i;
      stage2 <= stage1;
   end

   assign sync.nmi_n    = stage2[0];
   assign sync.irq_a_n  = stage2[1];
   assign sync.irq_b_n  = stage2[2];
   assign sync.stop_n   = stage2[3];
   assign sync.wait_req = stage2[4];
   assign sync.sleep_n  = stage2[5];
   assign sync.prog_n   = stage2[6];
   assign sync.mode     = stage2[8:7];
endmodule
`default_nettype wire

//--- tb/csc_ctrl_props.sv
// Concurrent checks on the pins of the CPU state controller.
`default_nettype none
module csc_ctrl_props (
   input wire logic        mclk_i,
   input wire logic        nrst_i,
   input wire logic        memory_wait_req_i,
   input wire logic        prog_select_n_i,
   input wire logic [4:0]  port7_out_i,
   input wire logic        bus_clock_out_o,
   input wire logic        bus_clock_oe_n_o,
   input wire logic        read_strobe_n_o,
   input wire logic        store_strobe_n_o,
   input wire logic        direction_is_read_o,
   input wire logic        opcode_fetch_n_o,
   input wire logic        bus_released_o,
   input wire logic [4:0]  strobe_pins_oe_n_o,
   input wire logic [1:0]  mode_o,
   input wire logic        irq_mask_o,
   input wire logic [15:0] vector_o,
   input wire logic        sys_tick_o,
   input wire logic        prog_enable_o,
   input wire logic [2:0]  state_o
);
   logic [3:0] quiet;
   logic [3:0] since_bclk;
   logic [3:0] since_tick;
   logic       exp_m;
   assign exp_m = mode_o != csc_pkg::MODE_SINGLE;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);
   // Period checks only count once stretching and stopped states lie well behind.
   always_ff @(posedge mclk_i) begin
      if (!nrst_i || memory_wait_req_i || state_o[2]) begin
         quiet <= 4'h0;
      end else if (quiet != 4'hF) begin
         quiet <= quiet + 4'h1;
      end
   end
   always_ff @(posedge mclk_i) begin
      since_bclk <= $rose(bus_clock_out_o) ? 4'h1 : since_bclk + 4'h1;
      since_tick <= sys_tick_o ? 4'h1 : since_tick + 4'h1;
   end
   sequence s_halted;
      (state_o == csc_pkg::CSC_HALT) [*2];
   endsequence
   sequence s_dozing;
      (state_o == csc_pkg::CSC_SLEEP && exp_m) [*2];
   endsequence
   a_bclk_period:
      assert property ($rose(bus_clock_out_o) && quiet == 4'hF |-> since_bclk == 4'h4)
      else $error("Bus clock period wrong.");
   a_tick_rate:
      assert property (sys_tick_o && quiet == 4'hF |-> since_tick == 4'h4)
      else $error("System tick rate wrong.");
   a_halt_pins:
      assert property (s_halted |-> bus_released_o && opcode_fetch_n_o
                       && strobe_pins_oe_n_o == 5'h07)
      else $error("Halt pin states wrong.");
   a_bus_held:
      assert property ((state_o != csc_pkg::CSC_HALT && exp_m) [*2] |-> !bus_released_o)
      else $error("Bus released outside halt.");
   a_strobe_pair:
      assert property (exp_m |-> (read_strobe_n_o || direction_is_read_o)
         && (store_strobe_n_o || !direction_is_read_o) && (read_strobe_n_o || store_strobe_n_o))
      else $error("Read and write strobes disagree.");
   a_fetch_only:
      assert property (exp_m && !opcode_fetch_n_o |-> state_o == csc_pkg::CSC_FETCH)
      else $error("Fetch strobe outside fetch.");
   a_sleep_pins:
      assert property (s_dozing |-> read_strobe_n_o && store_strobe_n_o
                       && direction_is_read_o && opcode_fetch_n_o && !bus_released_o)
      else $error("Sleep pin states wrong.");
   a_deep_sleep_n_float:
      assert property ((state_o == csc_pkg::CSC_DEEP_SLEEP_N) [*2] |-> bus_clock_oe_n_o
                       && strobe_pins_oe_n_o == 5'h1F)
      else $error("Standby pins driven.");
   a_single_nohalt:
      assert property (mode_o == csc_pkg::MODE_SINGLE |-> state_o != csc_pkg::CSC_HALT)
      else $error("Halt taken in single-chip mode.");
   a_single_port:
      assert property ((!exp_m && state_o inside {csc_pkg::CSC_FETCH, csc_pkg::CSC_EXEC}) [*2]
         |-> strobe_pins_oe_n_o == 5'h00 && {bus_released_o, opcode_fetch_n_o,
         direction_is_read_o, store_strobe_n_o, read_strobe_n_o} == $past(port7_out_i))
      else $error("Output port value wrong.");
   a_prog_off:
      assert property (prog_select_n_i [*5] |-> !prog_enable_o)
      else $error("Programming enabled while deselected.");
   a_reset_init:
      assert property ($rose(nrst_i) |-> irq_mask_o && vector_o == csc_pkg::VEC_RESET)
      else $error("Reset start values wrong.");
endmodule
bind csc_ctrl csc_ctrl_props csc_ctrl_props_inst (.*);
`default_nettype wire

//--- tb/csc_mem_model.sv
// Slow external memory that stretches each bus cycle with a wait request.
`default_nettype none
module csc_mem_model #(
   parameter int WAIT_CYC = 6
) (
   input  wire logic mclk_i,
   input  wire logic slow_i,
   input  wire logic bus_clock_i,
   input  wire logic read_strobe_n_i,
   input  wire logic store_strobe_n_i,
   output logic      memory_wait_req_o
);
   int   cnt    = 0;
   logic bclk_q = 1'b0;
   assign memory_wait_req_o = cnt != 0;
   always @(posedge mclk_i) begin
      bclk_q <= bus_clock_i;
      if (cnt != 0)
         cnt <= cnt - 1;
      else if (slow_i && bus_clock_i && !bclk_q && !(read_strobe_n_i && store_strobe_n_i))
         cnt <= WAIT_CYC;
   end
endmodule
`default_nettype wire

//--- tb/csc_ctrl_tb.sv
// Self-checking bench for the CPU state controller.
`default_nettype none
module csc_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk_i = 1'b0, nrst_i = 1'b0, osc_in = 1'b0, unmaskable_irq_n_i = 1'b1;
   logic level_irq_a_n_i = 1'b1, level_irq_b_n_i = 1'b1, mode_pin_0_i = 1'b1;
   logic mode_pin_1_i = 1'b1, stop_request_n_i = 1'b1, deep_sleep_n_i = 1'b1;
   logic prog_select_n_i = 1'b1, sleep_opcode_i = 1'b0, cycle_write_i = 1'b0;
   logic insn_last_i = 1'b0, irq_mask_clr_i = 1'b0, slow = 1'b0;
   logic [4:0]  port7_out_i = 5'h00;
   logic [7:0]  port4_ddr_i = 8'h00;
   logic        memory_wait_req_i, bus_clock_out_o, bus_clock_oe_n_o, read_strobe_n_o;
   logic        store_strobe_n_o, direction_is_read_o, opcode_fetch_n_o, bus_released_o;
   logic        addr_lo_oe_n_o, data_oe_n_o, bus_mode_o, port_keep_o, irq_mask_o;
   logic        sys_tick_o, prog_enable_o;
   logic [4:0]  strobe_pins_oe_n_o;
   logic [7:0]  addr_hi_oe_n_o, addr_hi_force_o;
   logic [1:0]  mode_o;
   logic [15:0] vector_o;
   logic [2:0]  state_o;
   int          err_total = 0, checks_done = 0, cycles = 0;
   wire logic [4:0] pins = {bus_released_o, opcode_fetch_n_o, direction_is_read_o,
                            store_strobe_n_o, read_strobe_n_o};
   csc_ctrl csc_ctrl_inst (.*);
   csc_mem_model csc_mem_model_inst (.mclk_i, .slow_i(slow), .bus_clock_i(bus_clock_out_o),
      .read_strobe_n_i(read_strobe_n_o), .store_strobe_n_i(store_strobe_n_o),
      .memory_wait_req_o(memory_wait_req_i));
   always #25 mclk_i = ~mclk_i;
   // The write flag flips each system cycle so both strobes get exercised.
   always @(posedge mclk_i) begin
      osc_in <= ~osc_in;
      if (sys_tick_o)
         cycle_write_i <= ~cycle_write_i;
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         err_total++;
         complete_run();
      end
   end
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
         err_total++;
      end
   endtask
   task automatic restart(input logic [1:0] m);
      @(posedge mclk_i);
      nrst_i <= 1'b0;
      {mode_pin_1_i, mode_pin_0_i} <= m;
      repeat (20) @(posedge mclk_i);
      nrst_i <= 1'b1;
      repeat (8) @(negedge mclk_i);
   endtask
   task automatic await_state(input logic [2:0] s);
      for (int i = 0; i < 800 && state_o !== s; i++)
         @(negedge mclk_i);
      repeat (2) @(negedge mclk_i);
      chk("state", 16'(s), 16'(state_o));
   endtask
   task automatic await_vec(input logic [15:0] v);
      for (int i = 0; i < 800 && vector_o !== v; i++)
         @(negedge mclk_i);
      chk("vector", v, vector_o);
   endtask
   task automatic t_clock(input logic stretch);
      int r;
      int t;
      int f;
      logic p;
      r = 0;
      t = 0;
      f = 0;
      p = bus_clock_out_o;
      repeat (40) begin
         @(negedge mclk_i);
         r += int'(bus_clock_out_o && !p);
         p = bus_clock_out_o;
         t += int'(sys_tick_o === 1'b1);
         f += int'(opcode_fetch_n_o === 1'b0);
      end
      chk("bus clock rises", stretch ? 16'h0001 : 16'h000A, 16'(stretch ? r < 10 : r));
      if (!stretch) chk("ticks", 16'h000A, 16'(t));
      chk("fetch seen", 16'h0001, 16'(f > 0));
   endtask
   task automatic t_halt;
      @(posedge mclk_i) stop_request_n_i <= 1'b0;
      await_state(csc_pkg::CSC_HALT);
      chk("halt pins", 16'h0067, 16'({pins[4:3], strobe_pins_oe_n_o}));
      @(posedge mclk_i) stop_request_n_i <= 1'b1;
      await_state(csc_pkg::CSC_FETCH);
      chk("released", 16'h0000, 16'(bus_released_o));
      @(posedge mclk_i) stop_request_n_i <= 1'b0;
      await_state(csc_pkg::CSC_HALT);
      @(posedge mclk_i) deep_sleep_n_i <= 1'b0;
      await_state(csc_pkg::CSC_DEEP_SLEEP_N);
      chk("standby floats", 16'h07FF, 16'({bus_clock_oe_n_o, addr_lo_oe_n_o, data_oe_n_o,
          addr_hi_oe_n_o}));
      @(posedge mclk_i);
      stop_request_n_i <= 1'b1;
      deep_sleep_n_i <= 1'b1;
   endtask
   task automatic t_single;
      int h;
      h = 0;
      @(posedge mclk_i);
      port7_out_i <= 5'h16;
      stop_request_n_i <= 1'b0;
      repeat (100) begin
         @(negedge mclk_i);
         h += int'(state_o === csc_pkg::CSC_HALT);
      end
      chk("halt in single", 16'h0000, 16'(h));
      chk("port pins", 16'h0016, 16'(pins));
      chk("port drive", 16'h0000, 16'(strobe_pins_oe_n_o));
      @(posedge mclk_i) stop_request_n_i <= 1'b1;
   endtask
   task automatic unmask;
      @(posedge mclk_i) irq_mask_clr_i <= 1'b1;
      for (int i = 0; i < 100 && irq_mask_o !== 1'b0; i++)
         @(negedge mclk_i);
      @(posedge mclk_i) irq_mask_clr_i <= 1'b0;
   endtask
   task automatic t_irq;
      @(posedge mclk_i) level_irq_a_n_i <= 1'b0;
      repeat (40) @(negedge mclk_i);
      unmask();
      await_vec(csc_pkg::VEC_IRQ);
      chk("mask after irq", 16'h0001, 16'(irq_mask_o));
      @(posedge mclk_i) level_irq_a_n_i <= 1'b1;
      @(posedge mclk_i) unmaskable_irq_n_i <= 1'b0;
      await_vec(csc_pkg::VEC_NMI);
      @(posedge mclk_i) unmaskable_irq_n_i <= 1'b1;
      unmask();
      port4_ddr_i <= 8'hA5;
      sleep_opcode_i <= 1'b1;
      await_state(csc_pkg::CSC_SLEEP);
      chk("sleep pins", 16'h000F, 16'(pins));
      chk("sleep keep", 16'h0001, 16'(port_keep_o));
      chk("upper dirs", 16'h5AA5, {addr_hi_oe_n_o, addr_hi_force_o & 8'hA5});
      @(posedge mclk_i);
      sleep_opcode_i <= 1'b0;
      level_irq_b_n_i <= 1'b0;
      await_vec(csc_pkg::VEC_IRQ);
      @(posedge mclk_i) level_irq_b_n_i <= 1'b1;
   endtask
   task automatic t_prog;
      @(posedge mclk_i) prog_select_n_i <= 1'b0;
      repeat (8) @(negedge mclk_i);
      chk("prog on", 16'h0001, 16'(prog_enable_o));
      @(posedge mclk_i) prog_select_n_i <= 1'b1;
      repeat (8) @(negedge mclk_i);
      chk("prog off", 16'h0000, 16'(prog_enable_o));
   endtask
   task automatic complete_run;
      $display("Comparisons %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (10) @(negedge mclk_i);
      chk("reset pins", 16'h000F, 16'(pins));
      chk("reset vector", csc_pkg::VEC_RESET, vector_o);
      for (int m = 1; m < 4; m++) begin
         restart(2'(m));
         chk("mode", 16'(m), 16'(mode_o));
         chk("bus mode", 16'(m != 3), 16'(bus_mode_o));
      end
      t_single();
      restart(csc_pkg::MODE_EXP2);
      t_clock(1'b0);
      @(posedge mclk_i) slow <= 1'b1;
      t_clock(1'b1);
      @(posedge mclk_i) slow <= 1'b0;
      t_halt();
      restart(csc_pkg::MODE_EXP2);
      t_irq();
      t_prog();
      complete_run();
   end
endmodule
`default_nettype wire
